// [rtl/csu_chip_select.sv]
// Purpose: Address decoder driving memory, peripheral and DRAM strobes.
// Assumes: Access fields stay stable while access.valid is high.
// Notes:   Early phase is address time, late phase follows one cycle after.
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`default_nettype none
module csu_chip_select (
    // Clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // Processor bus access
    input  wire csu_pkg::csu_access_s acc,
    input  wire logic               bus_hold,
    input  wire logic               upper_width_strap,
    // Pins: values and output enables
    output csu_pkg::csu_pins_s      pin_o,
    output csu_pkg::csu_pins_s      pin_oe,
    // AXI4-Lite write address
    input  wire logic [7:0]         s_awaddr,
    input  wire logic               s_awvalid,
    output logic                    s_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]        s_wdata,
    input  wire logic [3:0]         s_wstrb,
    input  wire logic               s_wvalid,
    output logic                    s_wready,
    // AXI4-Lite write response
    output logic [1:0]              s_bresp,
    output logic                    s_bvalid,
    input  wire logic               s_bready,
    // AXI4-Lite read
    input  wire logic [7:0]         s_araddr,
    input  wire logic               s_arvalid,
    output logic                    s_arready,
    output logic [31:0]             s_rdata,
    output logic [1:0]              s_rresp,
    output logic                    s_rvalid,
    input  wire logic               s_rready
);
    // Configuration registers
    logic [19:0] periph_base_r;
    logic        periph_io_r;
    logic [19:0] upper_base_r;
    logic [19:0] upper_size_r;
    logic        upper_dram_r;
    logic [19:0] lower_size_r;
    logic        lower_dram_r;
    logic [19:0] mid_base_r;
    logic [19:0] mid_size_r;
    logic        upper_x8_r;
    logic        strap_taken_r;
    logic [7:0]  aw_addr_r;
    logic        aw_have_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        w_have_r;
    logic        wr_go;
    logic        wr_hit;
    logic [31:0] wr_val;
    csu_pkg::csu_phase_e phase_r;
    csu_pkg::csu_pins_s  pins_r;

    // Write channel capture, either order
    assign s_awready = !aw_have_r && !s_bvalid;
    assign s_wready  = !w_have_r && !s_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r  <= 32'h00000000;
            w_strb_r  <= 4'h0;
            s_bvalid  <= 1'b0;
            s_bresp   <= 2'h0;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_wdata;
                w_strb_r <= s_wstrb;
            end
            if (aw_have_r && w_have_r) begin
                aw_have_r <= 1'b0;
                w_have_r  <= 1'b0;
                s_bvalid  <= 1'b1;
                s_bresp   <= wr_hit ? 2'h0 : 2'h2;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // Decode of the pending write
    assign wr_go  = aw_have_r && w_have_r;
    assign wr_hit = aw_addr_r == csu_pkg::OFS_PERIPH
                 || aw_addr_r == csu_pkg::OFS_UPPER
                 || aw_addr_r == csu_pkg::OFS_LOWER
                 || aw_addr_r == csu_pkg::OFS_MID
                 || aw_addr_r == csu_pkg::OFS_STATUS;
    // Byte lanes masked, unstrobed lanes write as zero; written word applies whole only on full strobes
    assign wr_val = w_data_r & {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                                {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

    // Peripheral block base and space
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            periph_base_r <= 20'h00000;
            periph_io_r   <= 1'b1;
        end else if (wr_go && aw_addr_r == csu_pkg::OFS_PERIPH) begin
            periph_base_r <= {wr_val[19:11], 11'h000}; // [RULE2]
            periph_io_r   <= wr_val[31];               // [RULE1]
        end
    end

    // Upper block: base in 64K units, size code, DRAM flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            upper_base_r <= csu_pkg::UPPER_BASE_RST; // [RULE9]
            upper_size_r <= csu_pkg::UPPER_SIZE_RST; // [RULE9]
            upper_dram_r <= 1'b0;
        end else if (wr_go && aw_addr_r == csu_pkg::OFS_UPPER) begin
            upper_base_r <= {wr_val[19:16], 16'h0000}; // [RULE6]
            // Size clipped to the largest block allowed
            upper_size_r <= (wr_val[27:20] > 8'h08) ? csu_pkg::MAX_BLOCK
                          : {wr_val[23:20], 16'h0000}; // [RULE6]
            upper_dram_r <= wr_val[31];
        end
    end

    // Lower block from address zero upward
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lower_size_r <= csu_pkg::LOWER_SIZE_RST;
            lower_dram_r <= 1'b0;
        end else if (wr_go && aw_addr_r == csu_pkg::OFS_LOWER) begin
            lower_size_r <= (wr_val[27:20] > 8'h08) ? csu_pkg::MAX_BLOCK
                          : {wr_val[23:20], 16'h0000}; // [RULE14]
            lower_dram_r <= wr_val[31];
        end
    end

    // Midrange block base and size
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mid_base_r <= 20'h00000;
            mid_size_r <= 20'h00000;
        end else if (wr_go && aw_addr_r == csu_pkg::OFS_MID) begin
            mid_base_r <= {wr_val[19:13], 13'h0000};         // [RULE15]
            mid_size_r <= {wr_val[27:20], 12'h000} & 20'hFF000;
        end
    end

    // Strap caught in the first cycle after reset release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_taken_r <= 1'b0;
            upper_x8_r    <= 1'b0;
        end else if (!strap_taken_r) begin
            strap_taken_r <= 1'b1;
            upper_x8_r    <= upper_width_strap; // [RULE8]
        end
    end

    // Register read path, one cycle latency
    assign s_arready = !s_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_rvalid <= 1'b0;
            s_rdata  <= 32'h00000000;
            s_rresp  <= 2'h0;
        end else if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rresp  <= 2'h0;
            case (s_araddr)
                csu_pkg::OFS_PERIPH: s_rdata <= {periph_io_r, 11'h000,
                                                 periph_base_r};
                csu_pkg::OFS_UPPER:  s_rdata <= {upper_dram_r, 7'h00,
                                                 upper_size_r[19:16],
                                                 upper_base_r};
                csu_pkg::OFS_LOWER:  s_rdata <= {lower_dram_r, 7'h00,
                                                 lower_size_r[19:16],
                                                 20'h00000};
                csu_pkg::OFS_MID:    s_rdata <= {4'h0, mid_size_r[19:12],
                                                 mid_base_r};
                csu_pkg::OFS_STATUS: s_rdata <= {28'h0000000, phase_r[2],
                                                 bus_hold, strap_taken_r,
                                                 upper_x8_r};
                default: begin
                    s_rdata <= 32'h00000000;
                    s_rresp <= 2'h2;
                end
            endcase
        end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
        end
    end

    // Address decode of the current access
    logic        hit_upper;
    logic        hit_lower;
    logic        hit_mid;
    logic        hit_periph;
    logic [19:0] mid_off;
    logic [19:0] per_off;
    logic [2:0]  per_idx;
    logic [1:0]  mid_idx;
    assign mid_off    = acc.addr - mid_base_r;
    assign per_off    = acc.addr - periph_base_r;
    assign per_idx    = per_off[csu_pkg::PERIPH_SHIFT +: 3];
    assign mid_idx    = mid_off[19:18] & 2'h3;
    // Priority makes decode exclusive when regions overlap
    assign hit_upper  = !acc.is_io && acc.addr >= upper_base_r
                     && ({1'b0, acc.addr} < ({1'b0, upper_base_r}
                                           + {1'b0, upper_size_r})); // [RULE5]
    assign hit_lower  = !acc.is_io && !hit_upper
                     && acc.addr < lower_size_r; // [RULE14]
    assign hit_mid    = !acc.is_io && !hit_upper && !hit_lower
                     && acc.addr >= mid_base_r && mid_off < mid_size_r;
    assign hit_periph = (acc.is_io == periph_io_r) && !hit_upper
                     && !hit_lower && !hit_mid
                     && per_off < 20'h00800; // [RULE1]

    // Access phase: early at address time, late one cycle on
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_r <= csu_pkg::CSU_IDLE;
        end else begin
            case (phase_r)
                csu_pkg::CSU_IDLE:  phase_r <= acc.valid ? csu_pkg::CSU_EARLY
                                                         : csu_pkg::CSU_IDLE;
                csu_pkg::CSU_EARLY: phase_r <= acc.valid ? csu_pkg::CSU_LATE
                                                         : csu_pkg::CSU_IDLE;
                csu_pkg::CSU_LATE:  phase_r <= acc.valid ? csu_pkg::CSU_LATE
                                                         : csu_pkg::CSU_IDLE;
                default:            phase_r <= csu_pkg::CSU_IDLE;
            endcase
        end
    end

    // Pin values, registered; all inactive high
    logic act;
    logic late;
    assign act  = acc.valid && !bus_hold;
    assign late = act && phase_r != csu_pkg::CSU_IDLE; // [RULE4]
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins_r <= '1;
        end else begin
            pins_r <= '1;
            // Early timing: asserts one cycle after acc.valid rises, in the early phase; mid_n[0] below uses late timing
            pins_r.upper_n <= !(act && hit_upper);            // [RULE4]
            pins_r.lower_n <= !(act && hit_lower);            // [RULE13]
            pins_r.mid_n[3] <= !(act && ((hit_mid && mid_idx == 2'h3)
                                || (hit_upper && upper_dram_r))); // [RULE12]
            pins_r.mid_n[0] <= !(late && hit_mid && mid_idx == 2'h0);
            // Pins shared with column strobes in DRAM mode
            if (upper_dram_r || lower_dram_r) begin
                pins_r.col_n[0] <= !(late && (hit_upper || hit_lower)
                                     && (acc.wr_lo || !acc.wr_hi)); // [RULE11]
                pins_r.col_n[1] <= !(late && (hit_upper || hit_lower)
                                     && (acc.wr_hi || !acc.wr_lo)); // [RULE10]
            end else begin
                pins_r.mid_n[1] <= !(late && hit_mid && mid_idx == 2'h1);
                pins_r.mid_n[2] <= !(late && hit_mid && mid_idx == 2'h2);
            end
            pins_r.periph_n <= ~({7'h00, late && hit_periph}
                                 << per_idx);                 // [RULE1]
        end
    end

    // Drive enables: released under reset and bus hold
    always_comb begin
        pin_oe = '1;
        pin_o  = pins_r;
        if (!aresetn || bus_hold) begin
            pin_oe.periph_n = 8'h00;  // [RULE3]
            pin_oe.upper_n  = 1'b0;   // [RULE7]
            pin_oe.lower_n  = 1'b0;
            pin_oe.mid_n    = 4'h0;
            pin_oe.col_n    = 2'h0;
        end
        if (!(upper_dram_r || lower_dram_r)) begin
            pin_oe.col_n = 2'h0;
        end
    end

    // Upper select seen low for an upper access in the next cycle
    a_upper_early: assert property ( // [RULE5]
        @(posedge aclk) disable iff (!aresetn)
        act && hit_upper |=> !pins_r.upper_n)
        else $error("upper select missed");
    a_one_select: assert property ( // [RULE16]
        @(posedge aclk) disable iff (!aresetn)
        $onehot0({~pins_r.periph_n, !pins_r.upper_n, !pins_r.lower_n}))
        else $error("more than one select");
    a_hold_float: assert property ( // [RULE3] [RULE7]
        @(posedge aclk) disable iff (!aresetn)
        bus_hold |-> pin_oe.periph_n == 8'h00 && !pin_oe.upper_n)
        else $error("selects driven in hold");
    sequence s_rst_rel;
        !aresetn ##1 aresetn;
    endsequence
    a_reset_window: assert property ( // [RULE9]
        @(posedge aclk)
        s_rst_rel |-> upper_base_r == 20'hF0000
                      && upper_size_r == 20'h10000)
        else $error("upper reset window wrong");
    a_periph_late: assert property ( // [RULE4]
        @(posedge aclk) disable iff (!aresetn)
        phase_r == csu_pkg::CSU_IDLE |=> pins_r.periph_n == 8'hFF)
        else $error("peripheral select too early");
    a_strap_once: assert property ( // [RULE8]
        @(posedge aclk) disable iff (!aresetn)
        strap_taken_r |=> $stable(upper_x8_r))
        else $error("strap width changed");
    a_upper_max: assert property ( // [RULE6]
        @(posedge aclk) disable iff (!aresetn)
        upper_size_r <= csu_pkg::MAX_BLOCK)
        else $error("upper block too large");
    a_row_upper: assert property ( // [RULE12]
        @(posedge aclk) disable iff (!aresetn)
        act && hit_upper && upper_dram_r |=> !pins_r.mid_n[3])
        else $error("upper row strobe missing");
endmodule
`default_nettype wire

// [rtl/csu_pkg.sv]
// Purpose: Constants, types and register map for the chip-select unit.
// Assumes: AXI4-Lite register access, 32-bit words, 20-bit bus addresses.
// Notes:   All selects and strobes are active low at the pins.
// Summary of operation
// [RULE1] Eight peripheral selects, I/O or memory space
// [RULE2] Peripheral block base programmable, regions relative
// [RULE3] Peripheral selects float during reset and hold
// [RULE4] Peripheral late timing; upper/lower early timing
// [RULE5] Upper select asserts inside upper block
// [RULE6] Upper base and size programmable, 512K max
// [RULE7] Upper select floats during reset and hold
// [RULE8] Upper width chosen by strap at reset
// [RULE9] Reset window F0000h-FFFFFh covers FFFF0h
// [RULE10] DRAM mode drives two column strobes
// [RULE11] Column strobes qualify low/high byte writes
// [RULE12] Upper DRAM row strobe on midrange 3
// [RULE13] Lower DRAM row strobe on lower pin
// [RULE14] Lower select asserts inside lower block
// [RULE15] Midrange selects assert in own regions
// [RULE16] Active low, one select, held whole access
`default_nettype none
package csu_pkg;
    localparam int ADDR_W = 20;
    // Register byte offsets
    localparam logic [7:0] OFS_PERIPH = 8'h00;
    localparam logic [7:0] OFS_UPPER  = 8'h04;
    localparam logic [7:0] OFS_LOWER  = 8'h08;
    localparam logic [7:0] OFS_MID    = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    // Reset values and the largest block size
    localparam logic [19:0] UPPER_BASE_RST = 20'hF0000;
    localparam logic [19:0] UPPER_SIZE_RST = 20'h10000;
    localparam logic [19:0] MAX_BLOCK      = 20'h80000;
    localparam logic [19:0] LOWER_SIZE_RST = 20'h00000;
    // Each peripheral region is 256 bytes: shift of region index
    localparam int PERIPH_SHIFT = 8;
    localparam int MID_SHIFT    = 2;
    // Bus cycle phases
    typedef enum logic [2:0] {
        CSU_IDLE  = 3'b001,
        CSU_EARLY = 3'b010,
        CSU_LATE  = 3'b100
    } csu_phase_e;
    // Processor bus access request
    typedef struct packed {
        logic        valid;
        logic        is_io;
        logic [19:0] addr;
        logic        wr_lo;
        logic        wr_hi;
    } csu_access_s;
    // Pin group: select value and output enable per pin
    typedef struct packed {
        logic [7:0] periph_n;
        logic       upper_n;
        logic       lower_n;
        logic [3:0] mid_n;
        logic [1:0] col_n;
    } csu_pins_s;
endpackage
`default_nettype wire

// [bench/csu_mem_model.sv]
// Purpose: Board side of the select pins: pull-ups and the memories.
// Assumes: Every select and strobe line carries a pull-up.
// Notes:   Flags two upper, lower or peripheral selects low together.
`default_nettype none
module csu_mem_model (
    // Pins from the unit
    input  wire csu_pkg::csu_pins_s pin_o,
    input  wire csu_pkg::csu_pins_s pin_oe,
    // Levels seen by the memories
    output var csu_pkg::csu_pins_s  pins_w,
    output var logic                multi_sel
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] sel_w;
    // A released line floats up to the inactive level
    assign pins_w = csu_pkg::csu_pins_s'(pin_o | ~pin_oe);
    // Strobes excluded: in DRAM mode they go low beside a select
    assign sel_w = ~{pins_w.periph_n, pins_w.upper_n, pins_w.lower_n};
    assign multi_sel = ($countones(sel_w) > 1);
endmodule
`default_nettype wire

// [bench/csu_chip_select_tb_top.sv]
// Purpose: Self-checking bench for the chip-select unit.
// Assumes: Pins are checked through the pull-up model.
// Notes:   Notes queue per result kind, compared by watcher processes.
`default_nettype none
module csu_chip_select_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 aclk, aresetn, bus_hold, strap, chk, multi_sel;
    csu_pkg::csu_access_s acc;
    csu_pkg::csu_pins_s   pin_o, pin_oe, pins_w;
    logic [7:0]           s_awaddr, s_araddr;
    logic [31:0]          s_wdata, s_rdata, seed, r;
    logic [3:0]           s_wstrb;
    logic [1:0]           s_bresp, s_rresp;
    logic                 s_awvalid, s_awready, s_wvalid, s_wready;
    logic                 s_bvalid, s_bready, s_arvalid, s_arready;
    logic                 s_rvalid, s_rready;
    logic [31:0]          pq[$];
    logic [65:0]          rq[$];
    logic [1:0]           bq[$];
    int                   n_fail, cmp_count;

    csu_chip_select csu_chip_select_i (.aclk, .aresetn, .acc, .bus_hold,
        .upper_width_strap(strap), .pin_o, .pin_oe, .s_awaddr, .s_awvalid,
        .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
        .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
        .s_rresp, .s_rvalid, .s_rready);
    csu_mem_model csu_mem_model_i (.pin_o, .pin_oe, .pins_w, .multi_sel);

    // Free-running bus clock, 100 ns
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic fail(input string m);
        n_fail++;
        $display("ERROR %0t %s", $time, m);
    endtask
    task automatic complete_run();
        if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Pins settle after the edge, so they are judged at the falling edge
    always @(negedge aclk) begin
        if (chk && pq.size() > 0) begin
            r = pq.pop_front();
            cmp_count++;
            if ((((pins_w ^ r[15:0]) & r[31:16]) !== 16'h0000) ||
                (multi_sel !== 1'b0)) fail("pin levels");
        end
    end
    // Bus answers are taken at the edge that completes them
    always @(posedge aclk) begin
        if (s_bvalid && s_bready && bq.size() > 0) begin
            cmp_count++;
            if (s_bresp !== bq.pop_front()) fail("write response");
        end
        if (s_rvalid && s_rready && rq.size() > 0) begin
            cmp_count++;
            if ((s_rresp !== rq[0][65:64]) ||
                (((s_rdata ^ rq[0][31:0]) & rq[0][63:32]) !== 32'h0))
                fail("read data");
            void'(rq.pop_front());
        end
    end
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] e);
        logic aw_ok, w_ok;
        bq.push_back(e);
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (!aw_ok && s_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_awvalid <= 1'b0;
            end
            if (!w_ok && s_wready === 1'b1) begin
                w_ok = 1'b1;
                s_wvalid <= 1'b0;
            end
        end while (!(aw_ok && w_ok && s_bvalid === 1'b1));
        s_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, m,
                          input logic [1:0] re);
        logic ar_ok;
        rq.push_back({re, m, e});
        ar_ok = 1'b0;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (!ar_ok && s_arready === 1'b1) begin
                ar_ok = 1'b1;
                s_arvalid <= 1'b0;
            end
        end while (!(ar_ok && s_rvalid === 1'b1));
        s_rready <= 1'b0;
    endtask
    // One access: e1 is the early-phase look, e2 the late-phase look
    task automatic access(input logic [19:0] a, input logic io,
                          input logic [1:0] wr, input logic [15:0] e1, e2, m);
        @(posedge aclk);
        acc <= {1'b1, io, a, wr[0], wr[1]};
        @(posedge aclk);
        pq.push_back({m, e1});
        chk <= 1'b1;
        @(posedge aclk);
        pq.push_back({m, e2});
        @(posedge aclk);
        chk <= 1'b0;
        acc.valid <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        cmp_count++;
        if (pin_oe !== '0 || pins_w !== 16'hFFFF) fail("pins during reset");
        aresetn <= 1'b1;
    endtask
    // Hang guard, well beyond the few hundred cycles the tests need
    initial begin
        #(3000 * 100);
        n_fail++;
        complete_run();
    end
    initial begin
        {aresetn, bus_hold, chk, s_awvalid, s_wvalid, s_bready} = '0;
        {s_arvalid, s_rready, s_awaddr, s_araddr, s_wdata} = '0;
        acc = '0;
        strap = 1'b1;
        s_wstrb = 4'hF;
        n_fail = 0;
        cmp_count = 0;
        seed = 32'hFB0BA0E3;
        do_reset();
        axi_rd(8'h04, 32'h001F0000, 32'h00FF0000, 2'b00);
        axi_rd(8'h10, 32'h1, 32'h1, 2'b00);
        axi_rd(8'h20, 32'h0, 32'hFFFFFFFF, 2'b10);
        axi_wr(8'h20, rnd(), 2'b10);
        access(20'hFFFF0, 0, 0, 16'hFF7F, 16'hFF7F, 16'hFFC3);
        access(20'hEFFFF, 0, 0, 16'hFFFF, 16'hFFFF, 16'hFFC3);
        axi_wr(8'h00, 32'h80012800, 2'b00);
        for (int k = 0; k < 8; k++) begin
            r = rnd();
            access(20'h12800 + 20'(k * 256) + 20'(r[7:0]), 1, r[9:8], 16'hFFFF,
                   {~(8'h01 << k), 8'hFF}, 16'hFFC3);
        end
        access(20'h12900, 0, 0, 16'hFFFF, 16'hFFFF, 16'hFFC3);
        axi_wr(8'h04, 32'h00880000, 2'b00);
        access(20'h80000, 0, 0, 16'hFF7F, 16'hFF7F, 16'hFFC3);
        access(20'h7FFFF, 0, 0, 16'hFFFF, 16'hFFFF, 16'hFFC3);
        axi_wr(8'h04, 32'h00900000, 2'b00);
        access(20'h7FFFF, 0, 0, 16'hFF7F, 16'hFF7F, 16'hFFC3);
        access(20'h80000, 0, 0, 16'hFFFF, 16'hFFFF, 16'hFFC3);
        axi_wr(8'h04, 32'h801F0000, 2'b00);
        access(20'hFFFF0, 0, 1, 16'hFFDF, 16'hFFDE, 16'hFF63);
        access(20'hFFFF2, 0, 2, 16'hFFDF, 16'hFFDD, 16'hFF63);
        axi_wr(8'h04, 32'h001F0000, 2'b00);
        axi_wr(8'h08, 32'h80100000, 2'b00);
        access(20'h00100, 0, 3, 16'hFFBF, 16'hFFBC, 16'hFFC3);
        bus_hold <= 1'b1;
        access(20'hFFFF0, 0, 0, 16'hFFFF, 16'hFFFF, 16'hFFFF);
        cmp_count++;
        if (pin_oe !== '0) fail("pins driven in hold");
        bus_hold <= 1'b0;
        strap <= 1'b0;
        do_reset();
        axi_rd(8'h04, 32'h001F0000, 32'h80FF0000, 2'b00);
        axi_rd(8'h10, 32'h0, 32'h1, 2'b00);
        access(20'hFFFF0, 0, 0, 16'hFF7F, 16'hFF7F, 16'hFFC3);
        // Midrange block over the low space; regions are quarters of it
        axi_wr(8'h0C, 32'h0FF00000, 2'b00);
        axi_rd(8'h0C, 32'h0FF00000, 32'hFFFFFFFF, 2'b00);
        access(20'h00100, 0, 0, 16'hFFFF, 16'hFFFB, 16'hFFFF);
        access(20'h40000, 0, 0, 16'hFFFF, 16'hFFF7, 16'hFFFF);
        access(20'h80000, 0, 0, 16'hFFFF, 16'hFFEF, 16'hFFFF);
        access(20'hC0000, 0, 0, 16'hFFDF, 16'hFFDF, 16'hFFFF);
        complete_run();
    end
endmodule
`default_nettype wire
